// ===== shared/s2cc_pkg.sv
/*
 Constants for the stage 2 configuration check: field encodings,
 address size codes, effective sizes and architecture revisions.
 Assumes one clock domain; used by rtl/s2cc_top.sv and rtl/s2cc_size_dec.sv.
*/
package s2cc_pkg;
	localparam logic [1:0] GRAN_4K = 2'h0;
	localparam logic [1:0] GRAN_64K = 2'h1;
	localparam logic [1:0] GRAN_16K = 2'h2;
	localparam logic [1:0] GRAN_RSVD = 2'h3;
	localparam logic [2:0] PS_32 = 3'h0;
	localparam logic [2:0] PS_36 = 3'h1;
	localparam logic [2:0] PS_40 = 3'h2;
	localparam logic [2:0] PS_42 = 3'h3;
	localparam logic [2:0] PS_44 = 3'h4;
	localparam logic [2:0] PS_48 = 3'h5;
	localparam logic [2:0] PS_52 = 3'h6;
	localparam logic [2:0] PS_RSVD = 3'h7;
	localparam logic [5:0] BITS_32 = 6'h20;
	localparam logic [5:0] BITS_36 = 6'h24;
	localparam logic [5:0] BITS_40 = 6'h28;
	localparam logic [5:0] BITS_42 = 6'h2a;
	localparam logic [5:0] BITS_44 = 6'h2c;
	localparam logic [5:0] BITS_48 = 6'h30;
	localparam logic [5:0] BITS_52 = 6'h34;
	localparam logic FMT_32 = 1'b0;
	localparam logic FMT_64 = 1'b1;
	localparam int ADDR_W = 52;
	localparam int CFG_S2_BIT = 1;
	localparam int TTF_32_BIT = 0;
	localparam int TTF_64_BIT = 1;
	localparam logic [1:0] REV_FIRST = 2'h0;
	localparam logic [1:0] REV_SECOND = 2'h1;
	localparam logic [1:0] REV_LATER = 2'h2;
	localparam logic [2:0] RST_PS = 3'h0;
	localparam logic [5:0] RST_BITS = 6'h00;
	typedef enum logic [1:0] {S2CC_IDLE, S2CC_WALK, S2CC_ABORT} s2cc_state_e;
	typedef struct packed {
		s2cc_state_e state;
		logic walk_valid;
		logic cfg_err;
		logic addr_fault;
		logic [5:0] eff_bits;
		logic [1:0] gran;
		logic [ADDR_W-1:0] out_addr;
		logic out_valid;
	} s2cc_state_s;
endpackage : s2cc_pkg

// ===== rtl/s2cc_size_dec.sv
/*
 Size decoder: turns a three-bit output size code into a bit count,
 after revision aliasing and capping. Pure combinational logic.
*/
`timescale 1ns/1ns
module s2cc_size_dec
	import s2cc_pkg::*;
(
	// Code in
	input wire logic [2:0] code,
	input wire logic [2:0] cap_code,
	input wire logic [1:0] arch_rev,
	// Result
	output logic [2:0] eff_code,
	output logic [5:0] eff_bits
);
	logic [2:0] aliased;
	logic [2:0] cap_alias;

	function automatic logic [2:0] alias_code(input logic [2:0] c,
		input logic [1:0] rev);
		logic [2:0] r;
		r = c;
		if (rev == REV_FIRST && c >= PS_52)
			r = PS_48;
		else if (c == PS_RSVD)
			r = PS_52;
		return r;
	endfunction : alias_code

	always_comb
	begin
		aliased = alias_code(code, arch_rev);
		cap_alias = alias_code(cap_code, arch_rev);
		// Cap also absorbs reserved codes
		eff_code = (aliased > cap_alias) ? cap_alias : aliased;
		unique case (eff_code)
			PS_32: eff_bits = BITS_32;
			PS_36: eff_bits = BITS_36;
			PS_40: eff_bits = BITS_40;
			PS_42: eff_bits = BITS_42;
			PS_44: eff_bits = BITS_44;
			PS_48: eff_bits = BITS_48;
			default: eff_bits = BITS_52;
		endcase
	end
endmodule : s2cc_size_dec

// ===== rtl/s2cc_top.sv
/*
 Stage 2 configuration check. Takes the stage 2 fields of a stream
 table entry with a one-cycle request, checks legality, then checks each
 stage 2 output address seen up to and including the entry_done cycle against the effective output size.
 Assumes the fetch path holds the entry fields while entry_valid is high
 and the walker presents addresses only while walk_ok is high.
*/
`timescale 1ns/1ns
module s2cc_top
	import s2cc_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Implementation features
	input wire logic stage2_present_flag,
	input wire logic [1:0] table_format_support,
	input wire logic [2:0] impl_out_addr_cap,
	input wire logic [1:0] arch_rev,
	// Entry from the stream table fetch
	input wire logic entry_valid,
	input wire logic [1:0] stream_cfg,
	input wire logic entry_secure,
	input wire logic [1:0] s2_granule_sel,
	input wire logic [2:0] s2_out_addr_size,
	input wire logic s2_table_format,
	// Output address from the walker
	input wire logic addr_valid,
	input wire logic [ADDR_W-1:0] walk_addr,
	input wire logic entry_done,
	// Results
	output logic walk_ok,
	output logic cfg_err_pulse,
	output logic [5:0] effective_out_size,
	output logic [1:0] gran_eff,
	output logic out_valid,
	output logic [ADDR_W-1:0] out_addr,
	output logic addr_size_fault
);
	s2cc_state_s cur_r;
	s2cc_state_s cur_nxt;
	logic s2_en;
	logic [1:0] gran_in;
	logic [2:0] ps_in;
	logic fmt_in;
	logic [5:0] dec_bits;
	logic [5:0] eff_in;
	logic illegal;
	logic [ADDR_W-1:0] masked;
	logic [ADDR_W-1:0] over_mask;

	// Fields read as zero without stage 2 support
	assign gran_in = stage2_present_flag ? s2_granule_sel : 2'h0;
	assign ps_in = stage2_present_flag ? s2_out_addr_size : 3'h0;
	assign fmt_in = stage2_present_flag ? s2_table_format : 1'b0;
	assign s2_en = stream_cfg[CFG_S2_BIT] & stage2_present_flag;

	s2cc_size_dec u_dec (
		.code(ps_in),
		.cap_code(impl_out_addr_cap),
		.arch_rev(arch_rev),
		.eff_code(),
		.eff_bits(dec_bits)
	);

	always_comb
	begin
		eff_in = (fmt_in == FMT_32) ? BITS_40 : dec_bits;
		illegal = 1'b0;
		if (s2_en)
		begin
			if (fmt_in == FMT_32 && !table_format_support[TTF_32_BIT])
				illegal = 1'b1;
			if (fmt_in == FMT_64 && !table_format_support[TTF_64_BIT])
				illegal = 1'b1;
			if (entry_secure && fmt_in == FMT_32)
				illegal = 1'b1;
			// Reserved granule cannot be walked; reject
			if (gran_in == GRAN_RSVD)
				illegal = 1'b1;
		end
		// Wide outputs only with 52-bit size and 64KB granule
		masked = walk_addr;
		if (!(cur_r.eff_bits == BITS_52 && cur_r.gran == GRAN_64K))
			masked[51:48] = 4'h0;
		over_mask = '0;
		for (int i = 0; i < ADDR_W; i++)
			over_mask[i] = (i >= int'(cur_r.eff_bits));
	end

	always_comb
	begin
		cur_nxt = cur_r;
		cur_nxt.cfg_err = 1'b0;
		cur_nxt.out_valid = 1'b0;
		unique case (cur_r.state)
			S2CC_IDLE:
			begin
				if (entry_valid && illegal)
				begin
					cur_nxt.state = S2CC_ABORT;
					cur_nxt.cfg_err = 1'b1;
				end
				else if (entry_valid && s2_en)
				begin
					cur_nxt.state = S2CC_WALK;
					cur_nxt.walk_valid = 1'b1;
					cur_nxt.eff_bits = eff_in;
					cur_nxt.gran = gran_in;
					cur_nxt.addr_fault = 1'b0;
				end
				// Stage 2 off: granule not captured at all
			end
			S2CC_WALK:
			begin
				if (addr_valid)
				begin
					cur_nxt.out_valid = 1'b1;
					cur_nxt.out_addr = masked;
					cur_nxt.addr_fault = |(masked & over_mask);
				end
				if (entry_done)
				begin
					cur_nxt.state = S2CC_IDLE;
					cur_nxt.walk_valid = 1'b0;
				end
			end
			S2CC_ABORT:
				cur_nxt.state = S2CC_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			cur_r.state <= S2CC_IDLE;
			cur_r.walk_valid <= 1'b0;
			cur_r.cfg_err <= 1'b0;
			cur_r.addr_fault <= 1'b0;
			cur_r.eff_bits <= RST_BITS;
			cur_r.gran <= GRAN_4K;
			cur_r.out_addr <= '0;
			cur_r.out_valid <= 1'b0;
		end
		else
			cur_r <= cur_nxt;
	end

	assign walk_ok = cur_r.walk_valid;
	assign cfg_err_pulse = cur_r.cfg_err;
	assign effective_out_size = cur_r.eff_bits;
	assign gran_eff = cur_r.gran;
	assign out_valid = cur_r.out_valid;
	assign out_addr = cur_r.out_addr;
	assign addr_size_fault = cur_r.addr_fault;

	// Fault judged from the registered result, not the mask logic
	a_fault_on_wide: assert property (
		@(posedge ref_clk) disable iff (srst)
		out_valid
		|-> addr_size_fault == ((out_addr >> effective_out_size) != '0))
		else $error("fault does not match address width");
	a_no_fault_narrow: assert property (
		@(posedge ref_clk) disable iff (srst)
		out_valid && out_addr[51:48] == 4'h0
		&& effective_out_size >= BITS_48
		|-> !addr_size_fault)
		else $error("fault on in-range address");
	a_high_bits_zero: assert property (
		@(posedge ref_clk) disable iff (srst)
		out_valid && gran_eff != GRAN_64K
		|-> out_addr[51:48] == 4'h0)
		else $error("high bits passed with small granule");
	a_fmt32_size40: assert property (
		@(posedge ref_clk) disable iff (srst)
		$rose(walk_ok) && $past(fmt_in) == FMT_32
		|-> effective_out_size == BITS_40)
		else $error("32-bit format size not 40");
	a_size_capped: assert property (
		@(posedge ref_clk) disable iff (srst)
		$rose(walk_ok) && $past(fmt_in) == FMT_64
		|-> effective_out_size <= BITS_52
			&& (impl_out_addr_cap != PS_40
			|| effective_out_size <= BITS_40))
		else $error("effective size above cap");
	a_first_rev48: assert property (
		@(posedge ref_clk) disable iff (srst)
		walk_ok && arch_rev == REV_FIRST
		|-> effective_out_size <= BITS_48)
		else $error("first revision size above 48");
	a_second_rev_rsvd: assert property (
		@(posedge ref_clk) disable iff (srst)
		$rose(walk_ok) && $past(fmt_in) == FMT_64 && arch_rev == REV_SECOND
		&& $past(s2_out_addr_size) == PS_RSVD && impl_out_addr_cap == PS_52
		|-> effective_out_size == BITS_52)
		else $error("reserved size code not read as 52");
	a_size_decode: assert property (
		@(posedge ref_clk) disable iff (srst)
		$rose(walk_ok) && $past(fmt_in) == FMT_64
		&& $past(s2_out_addr_size) == PS_36 && impl_out_addr_cap >= PS_36
		|-> effective_out_size == BITS_36)
		else $error("36-bit size code misdecoded");
	a_cap_absorbs: assert property (
		@(posedge ref_clk) disable iff (srst)
		$rose(walk_ok) && $past(fmt_in) == FMT_64
		&& impl_out_addr_cap == PS_44 && $past(s2_out_addr_size) > PS_44
		|-> effective_out_size == BITS_44)
		else $error("above-cap code not held at cap");
	a_gran_capture: assert property (
		@(posedge ref_clk) disable iff (srst)
		cur_r.state == S2CC_IDLE && entry_valid && s2_en && !illegal
		|=> walk_ok && gran_eff == $past(s2_granule_sel))
		else $error("granule not captured");
	a_illegal_abort: assert property (
		@(posedge ref_clk) disable iff (srst)
		cur_r.state == S2CC_IDLE && entry_valid && illegal
		|=> cfg_err_pulse && !walk_ok ##1 !cfg_err_pulse)
		else $error("illegal entry not aborted");
	a_secure_fmt32: assert property (
		@(posedge ref_clk) disable iff (srst)
		cur_r.state == S2CC_IDLE && entry_valid && s2_en
		&& entry_secure && fmt_in == FMT_32
		|=> cfg_err_pulse)
		else $error("secure 32-bit entry accepted");
	a_unsup_fmt: assert property (
		@(posedge ref_clk) disable iff (srst)
		cur_r.state == S2CC_IDLE && entry_valid && s2_en
		&& !table_format_support[fmt_in]
		|=> cfg_err_pulse)
		else $error("unsupported format accepted");
	a_s2_off_quiet: assert property (
		@(posedge ref_clk) disable iff (srst)
		cur_r.state == S2CC_IDLE && entry_valid && !s2_en
		|=> !walk_ok && !cfg_err_pulse)
		else $error("disabled stage 2 reacted to fields");
	c_walk: cover property (@(posedge ref_clk) $rose(walk_ok));
	c_fault: cover property (@(posedge ref_clk) addr_size_fault);
	c_err: cover property (@(posedge ref_clk) cfg_err_pulse);
	c_wide: cover property (@(posedge ref_clk)
		out_valid && out_addr[51:48] != 4'h0);
	c_size40: cover property (@(posedge ref_clk)
		$rose(walk_ok) && effective_out_size == BITS_40);
endmodule : s2cc_top

// ===== tb/s2cc_walk_model.sv
/*
 Walker model for s2cc_top: one output address per walk, then done.
 Assumes the bench sets addr_in and lag before each entry.
*/
`timescale 1ns/1ns
module s2cc_walk_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// From the check and the bench
	input wire logic walk_ok,
	input wire logic [51:0] addr_in,
	input wire logic [3:0] lag,
	// To the check
	output logic addr_valid,
	output logic [51:0] walk_addr,
	output logic entry_done
);
	logic used;
	logic [3:0] cnt;
	initial
	begin
		addr_valid = 1'b0;
		entry_done = 1'b0;
		walk_addr = '0;
	end
	always @(posedge ref_clk)
	begin
		addr_valid <= 1'b0;
		entry_done <= addr_valid;
		// Released bus flips, so a stale value never matches
		if (addr_valid)
			walk_addr <= ~walk_addr;
		if (srst || !walk_ok)
		begin
			used <= 1'b0;
			cnt <= 4'h0;
		end
		else if (!used && cnt == lag)
		begin
			addr_valid <= 1'b1;
			walk_addr <= addr_in;
			used <= 1'b1;
		end
		else if (!used)
			cnt <= cnt + 4'h1;
	end
endmodule : s2cc_walk_model

// ===== tb/stage2_cfg_check_tb.sv
/*
 Bench for s2cc_top: corner entries, then random ones.
 Assumes s2cc_walk_model plays the stage 2 walker.
*/
`timescale 1ns/1ns
module stage2_cfg_check_tb;
	import s2cc_pkg::*;
	logic ref_clk = 0, srst = 1, stage2_present_flag = 0;
	logic entry_valid = 0, entry_secure = 0, s2_table_format = 0;
	logic [1:0] table_format_support = 0, arch_rev = 0;
	logic [1:0] stream_cfg = 0, s2_granule_sel = 0, gran_eff;
	logic [2:0] impl_out_addr_cap = 0, s2_out_addr_size = 0;
	logic addr_valid, entry_done, walk_ok, cfg_err_pulse, out_valid;
	logic addr_size_fault;
	logic [5:0] effective_out_size;
	logic [51:0] walk_addr, out_addr, addr_in = 0;
	logic [3:0] lag = 0;
	int err_total = 0, total_checks = 0, cyc = 0;
	logic [5:0] bt [0:6] = '{BITS_32, BITS_36, BITS_40, BITS_42,
		BITS_44, BITS_48, BITS_52};
	s2cc_top DUT (.ref_clk, .srst, .stage2_present_flag,
		.table_format_support, .impl_out_addr_cap, .arch_rev,
		.entry_valid, .stream_cfg, .entry_secure, .s2_granule_sel,
		.s2_out_addr_size, .s2_table_format, .addr_valid, .walk_addr,
		.entry_done, .walk_ok, .cfg_err_pulse, .effective_out_size,
		.gran_eff, .out_valid, .out_addr, .addr_size_fault);
	s2cc_walk_model WALK (.ref_clk, .srst, .walk_ok, .addr_in, .lag,
		.addr_valid, .walk_addr, .entry_done);
	always #5 ref_clk = ~ref_clk;
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			finish_test();
		end
	end
	task automatic chk(input logic [51:0] s, e, input string n);
		total_checks++;
		if (s !== e)
		begin
			err_total++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask : chk
	function automatic logic [2:0] alias_c(logic [2:0] c, logic [1:0] r);
		if (r == REV_FIRST && c > PS_48)
			return PS_48;
		return (c == PS_RSVD) ? PS_52 : c;
	endfunction : alias_c
	task automatic run(input logic p, input logic [1:0] t,
		input logic [2:0] cap, input logic [1:0] rv, cfg, g,
		input logic sec, input logic [2:0] c, input logic f,
		input logic [51:0] a);
		logic go, bad;
		logic [2:0] m, k;
		logic [5:0] eb;
		logic [51:0] ea;
		int i;
		go = p && cfg[1];
		bad = g == GRAN_RSVD || !t[f] || (sec && f == FMT_32);
		@(posedge ref_clk);
		{stage2_present_flag, table_format_support, impl_out_addr_cap,
			arch_rev, stream_cfg, s2_granule_sel, entry_secure,
			s2_out_addr_size, s2_table_format, entry_valid}
			<= {p, t, cap, rv, cfg, g, sec, c, f, 1'b1};
		addr_in <= a;
		lag <= 4'($urandom % 3);
		@(posedge ref_clk);
		entry_valid <= 1'b0;
		#1;
		chk(walk_ok, go && !bad, "walk_ok");
		chk(cfg_err_pulse, go && bad, "cfg_err");
		if (go && !bad)
		begin
			m = alias_c(cap, rv);
			k = alias_c(c, rv);
			eb = f == FMT_32 ? BITS_40 : bt[k < m ? k : m];
			ea = a;
			if (!(eb == BITS_52 && g == GRAN_64K))
				ea[51:48] = 4'h0;
			chk(effective_out_size, eb, "eff_size");
			chk(gran_eff, g, "gran");
			for (i = 0; i < 8 && out_valid !== 1'b1; i++)
				@(posedge ref_clk) #1;
			chk(out_valid, 1, "out_valid");
			chk(out_addr, ea, "out_addr");
			chk(addr_size_fault, (ea >> eb) != 0, "fault");
			for (i = 0; i < 8 && walk_ok !== 1'b0; i++)
				@(posedge ref_clk) #1;
			chk(walk_ok, 0, "walk_end");
		end
	endtask : run
	initial
	begin
		void'($urandom(33));
		repeat (8) @(posedge ref_clk);
		srst <= 1'b0;
		run(1, 3, 6, 2, 2, 1, 0, 6, 1, 52'h4_0000_0000_0000);
		run(1, 3, 6, 2, 2, 0, 0, 5, 1, 52'h2_0000_0000_0000);
		run(1, 3, 6, 2, 2, 0, 0, 6, 0, 52'h0_0100_0000_0000);
		run(1, 3, 6, 0, 2, 1, 0, 7, 1, 52'h0_8000_0000_0000);
		run(1, 3, 6, 1, 2, 1, 0, 7, 1, 52'h8_0000_0000_0000);
		run(1, 3, 2, 2, 2, 0, 0, 5, 1, 52'h0_0100_0000_0000);
		run(1, 3, 0, 2, 2, 0, 0, 0, 1, 52'h0_0000_8000_0000);
		run(1, 3, 0, 2, 2, 2, 0, 0, 1, 52'h0_0001_0000_0000);
		run(1, 3, 4, 2, 3, 2, 0, 4, 1, 52'h0_1000_0000_0000);
		run(1, 2, 6, 2, 2, 0, 0, 5, 0, 0);
		run(1, 1, 6, 2, 2, 0, 0, 5, 1, 0);
		run(1, 3, 6, 2, 2, 0, 1, 5, 0, 0);
		run(1, 3, 6, 2, 2, 3, 0, 5, 1, 0);
		run(1, 3, 6, 2, 0, 3, 0, 7, 0, 0);
		run(0, 3, 6, 2, 2, 3, 1, 7, 0, 0);
		$display("corner tests done");
		// Random codes stay off the reserved values
		repeat (300)
			run(1, 2'($urandom_range(1, 3)), 3'($urandom % 7),
				2'($urandom % 3), 2'($urandom), 2'($urandom % 3),
				1'($urandom), 3'($urandom % 7), 1'($urandom),
				52'({$urandom, $urandom} >> $urandom_range(12, 30)));
		$display("random tests done");
		finish_test();
	end
endmodule : stage2_cfg_check_tb
